// >>> common/npf_defs.vh
// Functional notes
// - Phase word sits high, zeros below, added.
// - Phase value N means N/65536 of cycle.
// - Signed or unsigned phase reads behave alike.
// - Four read/write 16-bit channel A phases.
// - Read/write 32-bit A frequency, presets one-three.
// - Frequency words reset to 0xc0000000.
// - Phase words reset to zero.
// - Separate read/write channel B preset-0 frequency.
// - Frequency equals word times rate over 2^32.
// - Interleaved mode: channel B copies channel A.
`ifndef NPF_DEFS_VH
`define NPF_DEFS_VH

// Register byte offsets
`define NPF_OFF_PHASE_A0 12'h224
`define NPF_OFF_FREQ_A1 12'h228
`define NPF_OFF_PHASE_A1 12'h22c
`define NPF_OFF_FREQ_A2 12'h230
`define NPF_OFF_PHASE_A2 12'h234
`define NPF_OFF_FREQ_A3 12'h238
`define NPF_OFF_PHASE_A3 12'h23c
`define NPF_OFF_FREQ_B0 12'h240
`define NPF_OFF_CTRL 12'h260
`define NPF_OFF_STAT 12'h264

// Internal register indices
`define NPF_IDX_PHASE_A0 4'h0
`define NPF_IDX_PHASE_A1 4'h1
`define NPF_IDX_PHASE_A2 4'h2
`define NPF_IDX_PHASE_A3 4'h3
`define NPF_IDX_FREQ_A1 4'h4
`define NPF_IDX_FREQ_A2 4'h5
`define NPF_IDX_FREQ_A3 4'h6
`define NPF_IDX_FREQ_B0 4'h7
`define NPF_IDX_CTRL 4'h8
`define NPF_IDX_STAT 4'h9
`define NPF_IDX_NONE 4'hf

// Reset values
`define NPF_FREQ_RST 32'hc0000000
`define NPF_PHASE_RST 16'h0000
`define NPF_SEL_RST 2'h0

// Field positions
`define NPF_CTRL_SEL_LSB 0
`define NPF_CTRL_ILV_BIT 4
`define NPF_STAT_HINT_BIT 8

// Bus responses
`define NPF_RESP_OKAY 2'b00
`define NPF_RESP_SLVERR 2'b10

`endif

// >>> rtl/npf_osc.v
`timescale 1ns/1ps
// Phase accumulator with a left-justified phase offset
module npf_osc #(
  parameter ACC_W = 32, // Accumulator width
  parameter PH_W = 16 // Phase offset width
)(
  input wire aclk, // System clock
  input wire aresetn, // Synchronous reset, active low
  input wire sample_en, // One pulse per converter sample
  input wire [ACC_W-1:0] ftw, // Frequency tuning word
  input wire [PH_W-1:0] poff, // Phase offset
  output reg [ACC_W-1:0] phase_r // Output phase
);

  reg [ACC_W-1:0] acc_r; // Running accumulator
  wire [ACC_W-1:0] poff_word; // Offset moved into top bits

  // Offset in upper half, zeros below
  assign poff_word = {poff, {(ACC_W-PH_W){1'b0}}};

  // Step by the tuning word each sample
  always @(posedge aclk) begin
    if (!aresetn) begin
      acc_r <= {ACC_W{1'b0}};
      phase_r <= {ACC_W{1'b0}};
    end else if (sample_en) begin
      // Modulo add: wrap gives f = ftw * fs / 2^32
      acc_r <= acc_r + ftw;
      // Same bits for signed or unsigned offset
      phase_r <= acc_r + poff_word;
    end
  end

endmodule

// >>> rtl/npf_preset_mux.v
`timescale 1ns/1ps
// Picks the frequency and phase pair of one preset
module npf_preset_mux #(
  parameter FW = 32, // Frequency word width
  parameter PW = 16 // Phase word width
)(
  input wire [1:0] sel, // Selected preset
  input wire [4*FW-1:0] freq_bus, // Preset 3..0 frequencies
  input wire [4*PW-1:0] phase_bus, // Preset 3..0 phases
  output reg [FW-1:0] ftw, // Chosen frequency
  output reg [PW-1:0] poff // Chosen phase
);

  // Pair follows the selection at once
  always @* begin
    case (sel)
      2'h0: begin
        ftw = freq_bus[FW-1:0];
        poff = phase_bus[PW-1:0];
      end
      2'h1: begin
        ftw = freq_bus[2*FW-1:FW];
        poff = phase_bus[2*PW-1:PW];
      end
      2'h2: begin
        ftw = freq_bus[3*FW-1:2*FW];
        poff = phase_bus[3*PW-1:2*PW];
      end
      default: begin
        ftw = freq_bus[4*FW-1:3*FW];
        poff = phase_bus[4*PW-1:3*PW];
      end
    endcase
  end

endmodule

// >>> rtl/npf_regs.v
`timescale 1ns/1ps
`include "npf_defs.vh"
// Preset frequency and phase registers behind AXI4-Lite
module npf_regs #(
  parameter ADDR_W = 12 // Byte address width
)(
  input wire aclk, // System clock
  input wire aresetn, // Synchronous reset, active low
  input wire [ADDR_W-1:0] s_axi_awaddr, // Write address
  input wire s_axi_awvalid, // Write address valid
  output wire s_axi_awready, // Write address ready
  input wire [31:0] s_axi_wdata, // Write data
  input wire [3:0] s_axi_wstrb, // Write byte strobes
  input wire s_axi_wvalid, // Write data valid
  output wire s_axi_wready, // Write data ready
  output wire [1:0] s_axi_bresp, // Write response
  output wire s_axi_bvalid, // Write response valid
  input wire s_axi_bready, // Write response ready
  input wire [ADDR_W-1:0] s_axi_araddr, // Read address
  input wire s_axi_arvalid, // Read address valid
  output wire s_axi_arready, // Read address ready
  output wire [31:0] s_axi_rdata, // Read data
  output wire [1:0] s_axi_rresp, // Read response
  output wire s_axi_rvalid, // Read data valid
  input wire s_axi_rready, // Read data ready
  input wire sample_en, // One pulse per converter sample
  input wire [31:0] chan_a_preset0_freq, // Preset-0 A frequency
  input wire [15:0] chan_b_preset0_phase, // Preset-0 B phase
  output wire [31:0] osc_a_phase, // Channel A oscillator phase
  output wire [31:0] osc_b_phase // Channel B oscillator phase
);

  // Phase words for channel A presets 0..3
  reg [15:0] chan_a_phase_r [0:3];
  // Frequency words for channel A presets 1..3
  reg [31:0] chan_a_freq_r [1:3];
  reg [31:0] chan_b_preset0_freq_r; // Channel B preset 0
  reg [1:0] sel_a_r; // Selected channel A preset
  reg ilv_r; // Interleaved single-channel mode
  reg hint_r; // Running frequency was changed

  // Write channel holding state
  reg aw_full_r; // Address captured
  reg [ADDR_W-1:0] aw_addr_r; // Captured address
  reg w_full_r; // Data captured
  reg [31:0] w_data_r; // Captured data
  reg [3:0] w_strb_r; // Captured strobes
  reg bvalid_r; // Response pending
  reg [1:0] bresp_r; // Response code

  // Read channel state
  reg rvalid_r; // Read data pending
  reg [31:0] rdata_r; // Read data
  reg [1:0] rresp_r; // Read response code

  wire do_wr; // Commit a write this cycle
  wire [3:0] wr_idx; // Target of the write
  wire [3:0] rd_idx; // Target of the read
  wire ar_take; // Read address taken
  reg [31:0] rd_mux; // Read value before the register
  wire hint_set; // Active frequency being written
  wire hint_clr; // Software clears the hint
  wire [31:0] freq_a_merged; // Strobed word for A freq
  wire [31:0] freq_b_merged; // Strobed word for B freq
  wire [31:0] phase_merged; // Strobed word for a phase
  wire [31:0] ftw_a; // Chosen A frequency
  wire [15:0] poff_a; // Chosen A phase
  wire [31:0] ftw_b; // Channel B frequency in use
  wire [15:0] poff_b; // Channel B phase in use
  integer i; // Reset loop index

  // Map a byte address onto a register index
  function [3:0] npf_decode;
    input [ADDR_W-1:0] addr;
    begin
      case (addr[11:0])
        `NPF_OFF_PHASE_A0: npf_decode = `NPF_IDX_PHASE_A0;
        `NPF_OFF_PHASE_A1: npf_decode = `NPF_IDX_PHASE_A1;
        `NPF_OFF_PHASE_A2: npf_decode = `NPF_IDX_PHASE_A2;
        `NPF_OFF_PHASE_A3: npf_decode = `NPF_IDX_PHASE_A3;
        `NPF_OFF_FREQ_A1: npf_decode = `NPF_IDX_FREQ_A1;
        `NPF_OFF_FREQ_A2: npf_decode = `NPF_IDX_FREQ_A2;
        `NPF_OFF_FREQ_A3: npf_decode = `NPF_IDX_FREQ_A3;
        `NPF_OFF_FREQ_B0: npf_decode = `NPF_IDX_FREQ_B0;
        `NPF_OFF_CTRL: npf_decode = `NPF_IDX_CTRL;
        `NPF_OFF_STAT: npf_decode = `NPF_IDX_STAT;
        default: npf_decode = `NPF_IDX_NONE;
      endcase
    end
  endfunction

  // Merge new bytes into an old word under strobes
  function [31:0] npf_merge;
    input [31:0] old_w;
    input [31:0] new_w;
    input [3:0] strb;
    integer b;
    begin
      npf_merge = old_w;
      for (b = 0; b < 4; b = b + 1) begin
        if (strb[b]) begin
          npf_merge[8*b +: 8] = new_w[8*b +: 8];
        end
      end
    end
  endfunction

  // Bus handshake outputs
  assign s_axi_awready = !aw_full_r;
  assign s_axi_wready = !w_full_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  // Write commits once both halves are held
  assign do_wr = aw_full_r && w_full_r && !bvalid_r;
  assign wr_idx = npf_decode(aw_addr_r);
  assign rd_idx = npf_decode(s_axi_araddr);
  assign ar_take = s_axi_arvalid && !rvalid_r;

  // Capture write address and data in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r <= 1'b0;
      aw_addr_r <= {ADDR_W{1'b0}};
      w_full_r <= 1'b0;
      w_data_r <= 32'h00000000;
      w_strb_r <= 4'h0;
    end else begin
      // Address half
      if (s_axi_awvalid && !aw_full_r) begin
        aw_full_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end else if (do_wr) begin
        aw_full_r <= 1'b0;
      end
      // Data half
      if (s_axi_wvalid && !w_full_r) begin
        w_full_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end else if (do_wr) begin
        w_full_r <= 1'b0;
      end
    end
  end

  // Write response, error for unmapped offsets
  always @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= `NPF_RESP_OKAY;
    end else if (do_wr) begin
      bvalid_r <= 1'b1;
      if (wr_idx == `NPF_IDX_NONE) begin
        bresp_r <= `NPF_RESP_SLVERR;
      end else begin
        bresp_r <= `NPF_RESP_OKAY;
      end
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // Strobed words for the frequency targets
  assign freq_a_merged = npf_merge(chan_a_freq_r[wr_idx[1:0] + 2'h1],
    w_data_r, w_strb_r);
  assign freq_b_merged = npf_merge(chan_b_preset0_freq_r, w_data_r,
    w_strb_r);
  // Phase words only see the two low byte lanes
  assign phase_merged = npf_merge({16'h0000, chan_a_phase_r[wr_idx[1:0]]},
    w_data_r, {2'b00, w_strb_r[1:0]});

  // Preset register file
  always @(posedge aclk) begin
    if (!aresetn) begin
      for (i = 0; i < 4; i = i + 1) begin
        chan_a_phase_r[i] <= `NPF_PHASE_RST;
      end
      for (i = 1; i < 4; i = i + 1) begin
        chan_a_freq_r[i] <= `NPF_FREQ_RST;
      end
      chan_b_preset0_freq_r <= `NPF_FREQ_RST;
    end else if (do_wr) begin
      case (wr_idx)
        // Phase words take the two low lanes only
        `NPF_IDX_PHASE_A0, `NPF_IDX_PHASE_A1,
        `NPF_IDX_PHASE_A2, `NPF_IDX_PHASE_A3: begin
          chan_a_phase_r[wr_idx[1:0]] <= phase_merged[15:0];
        end
        // Frequency words, one register per preset 1..3
        `NPF_IDX_FREQ_A1, `NPF_IDX_FREQ_A2,
        `NPF_IDX_FREQ_A3: begin
          chan_a_freq_r[wr_idx[1:0] + 2'h1] <= freq_a_merged;
        end
        // Channel B keeps its own word
        `NPF_IDX_FREQ_B0: begin
          chan_b_preset0_freq_r <= freq_b_merged;
        end
        default: begin
        end
      endcase
    end
  end

  // Control fields: preset select and interleave
  always @(posedge aclk) begin
    if (!aresetn) begin
      sel_a_r <= `NPF_SEL_RST;
      ilv_r <= 1'b0;
    end else if (do_wr && wr_idx == `NPF_IDX_CTRL) begin
      if (w_strb_r[0]) begin
        sel_a_r <= w_data_r[`NPF_CTRL_SEL_LSB +: 2];
        ilv_r <= w_data_r[`NPF_CTRL_ILV_BIT];
      end
    end
  end

  // Writing a frequency in use leaves phase undetermined
  assign hint_set = do_wr && (w_strb_r != 4'h0) &&
    ((wr_idx == `NPF_IDX_FREQ_A1 && sel_a_r == 2'h1) ||
     (wr_idx == `NPF_IDX_FREQ_A2 && sel_a_r == 2'h2) ||
     (wr_idx == `NPF_IDX_FREQ_A3 && sel_a_r == 2'h3) ||
     (wr_idx == `NPF_IDX_FREQ_B0 && !ilv_r));
  assign hint_clr = do_wr && wr_idx == `NPF_IDX_STAT &&
    w_strb_r[1] && w_data_r[`NPF_STAT_HINT_BIT];

  // Sticky resync hint, a new set beats a clear
  always @(posedge aclk) begin
    if (!aresetn) begin
      hint_r <= 1'b0;
    end else if (hint_set) begin
      hint_r <= 1'b1;
    end else if (hint_clr) begin
      hint_r <= 1'b0;
    end
  end

  // Read value selection
  always @* begin
    rd_mux = 32'h00000000;
    case (rd_idx)
      `NPF_IDX_PHASE_A0, `NPF_IDX_PHASE_A1,
      `NPF_IDX_PHASE_A2, `NPF_IDX_PHASE_A3: begin
        rd_mux = {16'h0000, chan_a_phase_r[rd_idx[1:0]]};
      end
      `NPF_IDX_FREQ_A1, `NPF_IDX_FREQ_A2, `NPF_IDX_FREQ_A3: begin
        rd_mux = chan_a_freq_r[rd_idx[1:0] + 2'h1];
      end
      `NPF_IDX_FREQ_B0: begin
        rd_mux = chan_b_preset0_freq_r;
      end
      `NPF_IDX_CTRL: begin
        rd_mux[`NPF_CTRL_SEL_LSB +: 2] = sel_a_r;
        rd_mux[`NPF_CTRL_ILV_BIT] = ilv_r;
      end
      `NPF_IDX_STAT: begin
        rd_mux[`NPF_CTRL_SEL_LSB +: 2] = sel_a_r;
        rd_mux[`NPF_CTRL_ILV_BIT] = ilv_r;
        rd_mux[`NPF_STAT_HINT_BIT] = hint_r;
      end
      default: begin
        rd_mux = 32'h00000000;
      end
    endcase
  end

  // Read channel, answer one cycle after the address
  always @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= `NPF_RESP_OKAY;
    end else if (ar_take) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_mux;
      if (rd_idx == `NPF_IDX_NONE) begin
        rresp_r <= `NPF_RESP_SLVERR;
      end else begin
        rresp_r <= `NPF_RESP_OKAY;
      end
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // Channel A pair from the selected preset
  npf_preset_mux #(
    .FW(32),
    .PW(16)
  ) u_mux_a (
    .sel(sel_a_r),
    .freq_bus({chan_a_freq_r[3], chan_a_freq_r[2],
      chan_a_freq_r[1], chan_a_preset0_freq}),
    .phase_bus({chan_a_phase_r[3], chan_a_phase_r[2],
      chan_a_phase_r[1], chan_a_phase_r[0]}),
    .ftw(ftw_a),
    .poff(poff_a)
  );

  // Interleaved mode ignores channel B settings
  assign ftw_b = ilv_r ? ftw_a : chan_b_preset0_freq_r;
  assign poff_b = ilv_r ? poff_a : chan_b_preset0_phase;

  // Channel A oscillator
  npf_osc #(
    .ACC_W(32),
    .PH_W(16)
  ) u_osc_a (
    .aclk(aclk),
    .aresetn(aresetn),
    .sample_en(sample_en),
    .ftw(ftw_a),
    .poff(poff_a),
    .phase_r(osc_a_phase)
  );

  // Channel B oscillator
  npf_osc #(
    .ACC_W(32),
    .PH_W(16)
  ) u_osc_b (
    .aclk(aclk),
    .aresetn(aresetn),
    .sample_en(sample_en),
    .ftw(ftw_b),
    .poff(poff_b),
    .phase_r(osc_b_phase)
  );

endmodule

// >>> rtl/npf_unused_placeholder_none.v
`timescale 1ns/1ps

// >>> tb/npf_regs_checker.sv
`timescale 1ns/1ps
// Bus handshake and oscillator timing checks on the register block ports
module npf_regs_checker (
  input wire aclk, // Clock
  input wire aresetn, // Reset, low
  input wire s_axi_awvalid, // AW valid
  input wire s_axi_awready, // AW ready
  input wire s_axi_wvalid, // W valid
  input wire s_axi_wready, // W ready
  input wire [1:0] s_axi_bresp, // B code
  input wire s_axi_bvalid, // B valid
  input wire s_axi_bready, // B ready
  input wire s_axi_arvalid, // AR valid
  input wire s_axi_arready, // AR ready
  input wire [31:0] s_axi_rdata, // R data
  input wire [1:0] s_axi_rresp, // R code
  input wire s_axi_rvalid, // R valid
  input wire s_axi_rready, // R ready
  input wire sample_en, // Sample pulse
  input wire [31:0] osc_a_phase // A phase
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Answers stand unchanged until taken
  chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  // One read at a time
  chk_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("arready while rvalid");
  chk_read_lat: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid && !s_axi_arready) else $error("read answer late");
  chk_aw_held: assert property (s_axi_awvalid && s_axi_awready |=>
    !s_axi_awready) else $error("awready while held");
  chk_write_lat: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  // Refused reads carry zero data
  chk_slverr_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'h2
    |-> s_axi_rdata == 32'h0) else $error("error read data");
  // Phase output moves only on a sample
  chk_osc_still: assert property (!sample_en |=> $stable(osc_a_phase))
    else $error("phase moved without sample");
  chk_reset_idle: assert property ($rose(aresetn) |-> !s_axi_bvalid &&
    !s_axi_rvalid && osc_a_phase == 32'h0) else $error("reset state");
  cov_write: cover property (s_axi_bvalid && s_axi_bready);
  cov_read: cover property (s_axi_rvalid && s_axi_rready);
  cov_slverr: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
  cov_sample: cover property (sample_en);
endmodule

bind npf_regs npf_regs_checker i_chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .sample_en(sample_en),
  .osc_a_phase(osc_a_phase));

// >>> tb/testbench.sv
`timescale 1ns/1ps
`include "npf_defs.vh"
// Self-checking bench for the preset register block
module testbench;
  reg aclk = 1'h0; // Clock
  reg aresetn = 1'h0; // Reset
  reg [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0; // Addresses
  reg s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  reg s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, sample_en = 1'h0;
  reg [31:0] s_axi_wdata = 32'h0, chan_a_preset0_freq = 32'h100;
  reg [3:0] s_axi_wstrb = 4'hf; // Strobes
  reg [15:0] chan_b_preset0_phase = 16'h4000; // B phase
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp; // Codes
  wire [31:0] s_axi_rdata, osc_a_phase, osc_b_phase; // Data out
  integer fail_count = 0, compares = 0; // Counters
  reg [31:0] acc_a = 32'h0, acc_b = 32'h0; // Reference accumulators

  // 50 MHz clock
  always #10 aclk = ~aclk;

  npf_regs i_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .sample_en(sample_en),
    .chan_a_preset0_freq(chan_a_preset0_freq),
    .chan_b_preset0_phase(chan_b_preset0_phase),
    .osc_a_phase(osc_a_phase), .osc_b_phase(osc_b_phase));

  // Verdict and end of run
  task finish_test;
    begin
      if (fail_count == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
    end
  endtask

  // Compare seen against expected
  task chk(input string nm, input [31:0] got, input [31:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("MISMATCH %0s exp %h got %h", nm, exp, got);
      end
    end
  endtask

  // Bounded wait ran out
  task tout(input integer n);
    begin
      if (n == 50) begin
        chk("handshake", 32'h0, 32'h1);
        finish_test;
      end
    end
  endtask

  // One write, address and data offered together
  task wr(input [11:0] a, input [31:0] d, input [3:0] s, input [1:0] er);
    integer n;
    begin
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      n = 0;
      while (n < 50) begin
        @(posedge aclk);
        n = n + 1;
        if (s_axi_awready) s_axi_awvalid <= 1'h0;
        if (s_axi_wready) s_axi_wvalid <= 1'h0;
        if (s_axi_bvalid) begin
          chk("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
          s_axi_bready <= 1'h0;
          n = 99;
        end
      end
      tout(n);
    end
  endtask

  // One read, judged against expected word and code
  task rd(input [11:0] a, input [31:0] exp, input [1:0] er);
    integer n;
    begin
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      n = 0;
      while (n < 50) begin
        @(posedge aclk);
        n = n + 1;
        if (s_axi_arready) s_axi_arvalid <= 1'h0;
        if (s_axi_rvalid) begin
          chk("rdata", s_axi_rdata, exp);
          chk("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
          s_axi_rready <= 1'h0;
          n = 99;
        end
      end
      tout(n);
    end
  endtask

  // Reset values of all eight preset registers
  task t_reset;
    integer i;
    reg [11:0] a;
    begin
      a = 12'h224;
      for (i = 0; i < 8; i = i + 1) begin
        if (i % 2 == 0 && i < 7) rd(a, 32'h0, `NPF_RESP_OKAY);
        else rd(a, `NPF_FREQ_RST, `NPF_RESP_OKAY);
        a = a + 12'h004;
      end
    end
  endtask

  // Distinct words written to all eight preset registers, one shared low half for the phases, then read back all
  task t_rw;
    integer i, k;
    reg [11:0] a;
    begin
      for (k = 0; k < 2; k = k + 1) begin
        a = 12'h224;
        for (i = 0; i < 8; i = i + 1) begin
          if (k == 0) wr(a, 32'ha5c31e70 + {i[7:0], 24'h0}, 4'hf, 2'h0);
          else if (i % 2 == 0 && i < 7) rd(a, 32'h1e70, 2'h0);
          else rd(a, 32'ha5c31e70 + {i[7:0], 24'h0}, 2'h0);
          a = a + 12'h004;
        end
      end
      wr(12'h224, 32'hffffffff, 4'h1, 2'h0);
      rd(12'h224, 32'h1eff, 2'h0);
    end
  endtask

  // Unmapped place refuses and leaves neighbours alone
  task t_bad;
    begin
      wr(12'h244, 32'h1234, 4'hf, `NPF_RESP_SLVERR);
      rd(12'h244, 32'h0, `NPF_RESP_SLVERR);
      rd(12'h240, 32'hacc31e70, 2'h0);
    end
  endtask

  // One sample, checked against the reference accumulators
  task pulse(input [31:0] fa, input [15:0] pa, input [31:0] fb,
      input [15:0] pb);
    reg [31:0] ea, eb;
    begin
      ea = acc_a + {pa, 16'h0};
      eb = acc_b + {pb, 16'h0};
      acc_a = acc_a + fa;
      acc_b = acc_b + fb;
      @(posedge aclk);
      sample_en <= 1'h1;
      @(posedge aclk);
      sample_en <= 1'h0;
      #1;
      chk("osc_a", osc_a_phase, ea);
      chk("osc_b", osc_b_phase, eb);
    end
  endtask

  // Preset switching, half cycle offset, wrap of signed phase, interleave
  task t_osc;
    begin
      wr(12'h224, 32'h1, 4'hf, 2'h0);
      wr(12'h228, 32'h0, 4'hf, 2'h0);
      wr(12'h22c, 32'h8000, 4'hf, 2'h0);
      wr(12'h230, 32'h10000, 4'hf, 2'h0);
      wr(12'h234, 32'hffff, 4'hf, 2'h0);
      wr(12'h240, 32'h20000, 4'hf, 2'h0);
      wr(`NPF_OFF_CTRL, 32'h0, 4'hf, 2'h0);
      pulse(32'h100, 16'h1, 32'h20000, 16'h4000);
      pulse(32'h100, 16'h1, 32'h20000, 16'h4000);
      wr(`NPF_OFF_CTRL, 32'h1, 4'hf, 2'h0);
      pulse(32'h0, 16'h8000, 32'h20000, 16'h4000);
      wr(`NPF_OFF_CTRL, 32'h2, 4'hf, 2'h0);
      pulse(32'h10000, 16'hffff, 32'h20000, 16'h4000);
      pulse(32'h10000, 16'hffff, 32'h20000, 16'h4000);
      wr(`NPF_OFF_CTRL, 32'h12, 4'hf, 2'h0);
      pulse(32'h10000, 16'hffff, 32'h10000, 16'hffff);
      pulse(32'h10000, 16'hffff, 32'h10000, 16'hffff);
    end
  endtask

  // Resync hint: sticky on an in-use frequency write, cleared by a one
  task t_hint;
    begin
      rd(`NPF_OFF_CTRL, 32'h12, 2'h0);
      rd(`NPF_OFF_STAT, 32'h112, 2'h0);
      wr(`NPF_OFF_STAT, 32'h100, 4'h2, 2'h0);
      rd(`NPF_OFF_STAT, 32'h12, 2'h0);
      wr(12'h238, 32'h10000, 4'hf, 2'h0);
      rd(`NPF_OFF_STAT, 32'h12, 2'h0);
      wr(12'h230, 32'h10000, 4'hf, 2'h0);
      rd(`NPF_OFF_STAT, 32'h112, 2'h0);
    end
  endtask

  // Main sequence
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    t_reset;
    t_rw;
    t_bad;
    t_osc;
    t_hint;
    finish_test;
  end
endmodule
